// ===== include/tpd_params.svh
// constants for the timer pin direction control block
// assumes a 100 MHz device clock and two timer channels
`ifndef TPD_PARAMS_SVH
`define TPD_PARAMS_SVH
`define TPD_NUM_CH      2
`define TPD_FN_W        2
`define TPD_FN_GPIN     2'h0
`define TPD_FN_GPOUT    2'h1
`define TPD_FN_TIMER    2'h2
`define TPD_MODE_W      3
`endif

// ===== include/tpd_pkg.sv
// types for the timer pin direction control block
// assumes tpd_params.svh is on the include path
package tpd_pkg;
  typedef enum logic [1:0] {
    TPD_GP_IN,
    TPD_GP_OUT,
    TPD_TIMER_IO
  } tpd_fn_t;
  typedef enum logic [2:0] {
    TPD_EVENT_CNT,
    TPD_MEASURE,
    TPD_WATCHDOG,
    TPD_PLAIN_TIMER,
    TPD_PULSE_MOD
  } tpd_mode_t;
endpackage : tpd_pkg

// ===== verilog/tpd_pin_ctrl.sv
// pin direction control for the two timer channel pins
// assumes control fields come from each channel's ctrl/stat register
// logic on clk_i; pins arrive asynchronously
`timescale 1ns/1ns
`include "tpd_params.svh"
module tpd_pin_ctrl #(
  parameter int NCH = `TPD_NUM_CH
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [NCH*2-1:0]      ch_fn_i,
  input  wire logic [NCH*3-1:0]      ch_mode_i,
  input  wire logic [NCH-1:0]        gp_dout_i,
  input  wire logic [NCH-1:0]        tmr_out_i,
  input  wire logic [NCH-1:0]        timer_pin_i,
  output logic      [NCH-1:0]        timer_pin_o,
  output logic      [NCH-1:0]        timer_pin_oe_b_o,
  output logic      [NCH-1:0]        gp_din_o,
  output logic      [NCH-1:0]        tmr_in_o
);

  ////////////////////////////////////////////////////////////////////////
  // helper: timer modes that drive the pin
  function automatic logic mode_drives(input logic [2:0] m);
    mode_drives = (m == 3'(tpd_pkg::TPD_WATCHDOG)) ||
                  (m == 3'(tpd_pkg::TPD_PLAIN_TIMER)) ||
                  (m == 3'(tpd_pkg::TPD_PULSE_MOD));
  endfunction : mode_drives

  logic [NCH-1:0] sync1_ff;
  logic [NCH-1:0] sync2_ff;
  logic [NCH-1:0] nxt_oe_b;
  logic [NCH-1:0] nxt_pin;

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= timer_pin_i;
      sync2_ff <= sync1_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      nxt_oe_b[i] = 1'b1;
      nxt_pin[i]  = 1'b0;
      unique case (ch_fn_i[i*2 +: 2])
        `TPD_FN_GPOUT: begin
          nxt_oe_b[i] = 1'b0;
          nxt_pin[i]  = gp_dout_i[i];
        end
        `TPD_FN_TIMER: begin
          // counter and measurement modes leave pin undriven
          nxt_oe_b[i] = !mode_drives(ch_mode_i[i*3 +: 3]);
          nxt_pin[i]  = tmr_out_i[i];
        end
        default: begin
          // gp input and illegal codes stay input, safe choice
          nxt_oe_b[i] = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pin drive; reset leaves every pin input
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_pin_oe_b_o <= '1;
      timer_pin_o      <= '0;
    end else begin
      timer_pin_oe_b_o <= nxt_oe_b;
      timer_pin_o      <= nxt_pin;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gp_din_o <= '0;
      tmr_in_o <= '0;
    end else begin
      gp_din_o <= sync2_ff;
      tmr_in_o <= sync2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < NCH; g++) begin : g_ast
    AST_INPUT_MODES: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_TIMER &&
       !mode_drives(ch_mode_i[g*3 +: 3])) |=> timer_pin_oe_b_o[g])
      else $error("timer pin driven in input mode");
    AST_OUTPUT_MODES: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_TIMER &&
       mode_drives(ch_mode_i[g*3 +: 3])) |=>
       (!timer_pin_oe_b_o[g] && timer_pin_o[g] == $past(tmr_out_i[g])))
      else $error("timer pin not driven in output mode");
    AST_GP_IN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_GPIN) |=> timer_pin_oe_b_o[g])
      else $error("gp input pin driven");
    AST_GP_OUT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_GPOUT) |=>
      (!timer_pin_oe_b_o[g] && timer_pin_o[g] == $past(gp_dout_i[g])))
      else $error("gp output not following data bit");
    AST_GP_READ: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ##3 gp_din_o[g] == $past(timer_pin_i[g], 3))
      else $error("gp input read value wrong");
  end

  ////////////////////////////////////////////////////////////////////////
  // per-code direction and drive value checks, then read path checks; one per mode so a slip in the
  // decode function shows up by name rather than as a group
  for (genvar g = 0; g < NCH; g++) begin : g_ast_code

    AST_FN3_IN: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == 2'h3) |=>
      timer_pin_oe_b_o[g])
      else $error("unused pin use code drives pin");

    AST_EVENT_IN: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_TIMER &&
       ch_mode_i[g*3 +: 3] == 3'(tpd_pkg::TPD_EVENT_CNT)) |=>
      timer_pin_oe_b_o[g]) else $error("event count mode drives pin");

    AST_MEASURE_IN: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_TIMER &&
       ch_mode_i[g*3 +: 3] == 3'(tpd_pkg::TPD_MEASURE)) |=>
      timer_pin_oe_b_o[g]) else $error("measure mode drives pin");

    AST_SPARE_MODE_IN: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_TIMER &&
       ch_mode_i[g*3 +: 3] > 3'(tpd_pkg::TPD_PULSE_MOD)) |=>
      timer_pin_oe_b_o[g]) else $error("spare mode code drives pin");

    AST_WATCHDOG_OUT: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_TIMER &&
       ch_mode_i[g*3 +: 3] == 3'(tpd_pkg::TPD_WATCHDOG)) |=>
      !timer_pin_oe_b_o[g]) else $error("watchdog mode leaves pin off");

    AST_PLAIN_OUT: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_TIMER &&
       ch_mode_i[g*3 +: 3] == 3'(tpd_pkg::TPD_PLAIN_TIMER)) |=>
      !timer_pin_oe_b_o[g]) else $error("timer mode leaves pin off");

    AST_PULSE_OUT: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_TIMER &&
       ch_mode_i[g*3 +: 3] == 3'(tpd_pkg::TPD_PULSE_MOD)) |=>
      !timer_pin_oe_b_o[g]) else $error("pulse mode leaves pin off");

    AST_TIMER_VALUE: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_TIMER) |=>
      (timer_pin_o[g] == $past(tmr_out_i[g])))
      else $error("timer drive value wrong");

    AST_GP_OUT_HI: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_GPOUT && gp_dout_i[g]) |=>
      timer_pin_o[g])
      else $error("gp output high not driven");

    AST_GP_OUT_LO: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_GPOUT && !gp_dout_i[g]) |=>
      !timer_pin_o[g])
      else $error("gp output low not driven");

    AST_GP_OUT_ENABLE: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_GPOUT) |=>
      !timer_pin_oe_b_o[g])
      else $error("gp output use leaves pin off");

    AST_GP_IN_LOW: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == `TPD_FN_GPIN) |=>
      !timer_pin_o[g])
      else $error("gp input use left drive value high");

    AST_FN3_LOW: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (ch_fn_i[g*2 +: 2] == 2'h3) |=>
      !timer_pin_o[g])
      else $error("unused use code left drive value high");

    AST_TMR_READ: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      ##3
      (tmr_in_o[g] == $past(timer_pin_i[g], 3)))
      else $error("timer input read value wrong");

    AST_SYNC_FIRST: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      1'b1 |=>
      (sync1_ff[g] == $past(timer_pin_i[g])))
      else $error("first sync stage missed pin");

    AST_SYNC_CHAIN: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      1'b1 |=>
      (sync2_ff[g] == $past(sync1_ff[g])))
      else $error("second sync stage missed first");

    AST_PATHS_AGREE: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      1'b1 |->
      (gp_din_o[g] == tmr_in_o[g]))
      else $error("software and timer pin reads differ");

  end

endmodule : tpd_pin_ctrl

// ===== verif/tpd_pin_partner.sv
// external source or load wired to the two timer pins
// assumes active-low output enable from the pin control
`timescale 1ns/1ns
module tpd_pin_partner (
  input  wire logic [1:0] drv_i,
  input  wire logic [1:0] oe_b_i,
  input  wire logic [1:0] src_i,
  output logic      [1:0] wire_o
);
  // released pins show the source, not the last drive
  assign wire_o = (~oe_b_i & drv_i) | (oe_b_i & src_i);
endmodule : tpd_pin_partner

// ===== verif/tb_timer_pin_direction_control.sv
// self-checking bench for the timer pin direction control
// assumes tpd_pin_ctrl with two channels and tpd_pin_partner
`timescale 1ns/1ns
module tb_timer_pin_direction_control;
  logic       clk_i, rst_b_i;
  logic [3:0] fn, e;
  logic [5:0] mode;
  logic [1:0] dout, tout, src, pin, drv, oe_b, din, tin;
  int         miscompares, n_checks, cyc;
  tpd_pin_ctrl #(.NCH(2)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .ch_fn_i(fn), .ch_mode_i(mode), .gp_dout_i(dout), .tmr_out_i(tout),
    .timer_pin_i(pin), .timer_pin_o(drv), .timer_pin_oe_b_o(oe_b),
    .gp_din_o(din), .tmr_in_o(tin));
  tpd_pin_partner ext (.drv_i(drv), .oe_b_i(oe_b), .src_i(src),
    .wire_o(pin));
  ////////////////////////////////////////////////////////////////////
  // low half: expected enable, high half: expected drive
  function automatic logic [3:0] exp_out();
    logic [3:0] r;
    for (int c = 0; c < 2; c++) begin
      r[c] = !(fn[2*c+:2] == 2'h1 || (fn[2*c+:2] == 2'h2 &&
             mode[3*c+:3] inside {3'h2, 3'h3, 3'h4}));
      r[c+2] = r[c] ? 1'b0 : (fn[2*c+:2] == 2'h1 ? dout[c] : tout[c]);
    end
    return r;
  endfunction : exp_out
  task automatic check(input string nm, input logic [3:0] s, x);
    n_checks++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // bound well above the 511 cycles the tests need
  always @(posedge clk_i) if (++cyc == 2000) begin
    miscompares++;
    report_and_stop();
  end
  initial begin
    rst_b_i = 0; fn = 0; mode = 0; dout = 0; tout = 0; src = 0;
    miscompares = 0; n_checks = 0; cyc = 0;
    void'($urandom(32'h9116));
    repeat (8) @(posedge clk_i);
    check("reset oe_b", oe_b, 4'h3);
    rst_b_i <= 1;
    repeat (4) @(negedge clk_i);
    check("idle oe_b", oe_b, 4'h3);
    check("idle din", din, src);
    $display("reset test done");
    // first 32 walk every use and mode code on channel 0, then random
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_i);
      fn <= (i < 32) ? {2'($urandom), 2'(i)} : 4'($urandom);
      mode <= (i < 32) ? {3'($urandom), 3'(i >> 2)} : 6'($urandom);
      dout <= 2'($urandom);
      tout <= 2'($urandom);
      src <= 2'($urandom);
      repeat (2) @(negedge clk_i);
      e = exp_out();
      check("drive", {drv & ~e[1:0], oe_b}, e);
      repeat (3) @(negedge clk_i);
      check("gp in", din, (~e[1:0] & e[3:2]) | (e[1:0] & src));
      check("tmr in", tin, (~e[1:0] & e[3:2]) | (e[1:0] & src));
    end
    $display("mode test done");
    report_and_stop();
  end
endmodule : tb_timer_pin_direction_control
